// ---- hw/cido_params.svh ----
`ifndef CIDO_PARAMS_SVH
`define CIDO_PARAMS_SVH
// register byte offsets
`define CIDO_OFF_INSTR    12'h000
`define CIDO_OFF_STATUS   12'h004
`define CIDO_OFF_ACC      12'h008
`define CIDO_OFF_PTR0     12'h00c
`define CIDO_OFF_PTR1     12'h010
`define CIDO_OFF_PC       12'h014
`define CIDO_OFF_PRESC    12'h018
`define CIDO_OFF_CYCLES   12'h01c
`define CIDO_OFF_DIR      12'h040
`define CIDO_MASK_DIR     12'hfe0
`define CIDO_OFF_FILE     12'h200
`define CIDO_MASK_FILE    12'he00
// status word field positions
`define CIDO_ST_BUSY      0
`define CIDO_ST_PREF      1
`define CIDO_ST_DISC      2
`define CIDO_ST_SLEEP     3
`define CIDO_ST_C         8
`define CIDO_ST_DC        9
`define CIDO_ST_Z         10
`define CIDO_ST_TO        11
`define CIDO_ST_PD        12
// reset values
`define CIDO_RST_BYTE     8'h00
`define CIDO_RST_PTR      16'h0000
`define CIDO_RST_NFLAG    1'b1
// opcode patterns
`define CIDO_OP_BRW       14'h000b
`define CIDO_OP_CALL_BY_ACC     14'h000a
`define CIDO_OP_OPTION    14'h0062
`define CIDO_OP_SLEEP     14'h0063
`define CIDO_OP_CLRWDT    14'h0064
`define CIDO_OP_DIRECTION_LOAD      11'h00c
`define CIDO_OP_LOAD_MOD  11'h002
`define CIDO_OP_STORE_MOD 11'h003
`define CIDO_OP_BRA       5'h19
`define CIDO_OP_RETURN_LITERAL     6'h34
`define CIDO_OP_POINTER_OFFSET_ADD    7'h62
`define CIDO_OP_LOAD_IDX  7'h7e
`define CIDO_OP_STORE_IDX 7'h7f
`define CIDO_OP_LITERAL_ADD     6'h3e
`define CIDO_OP_LITERAL_AND     6'h39
`define CIDO_OP_FILE_AND     6'h05
`endif

// ---- hw/cido_pkg.sv ----
package cido_pkg;
  // one-hot sequencer states
  typedef enum logic [3:0] {
    s_idle  = 4'h1,
    s_exec  = 4'h2,
    s_flush = 4'h4,
    s_extra = 4'h8
  } cido_state_type;
endpackage : cido_pkg

// ---- hw/cido_core.sv ----
`timescale 1ns/1ps
`include "cido_params.svh"
module cido_core #(
  parameter int PC_W        = 15,
  parameter int STACK_DEPTH = 16
) (
  input  wire logic        pclk,          // bus clock
  input  wire logic        presetn,       // async reset, low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb direction
  input  wire logic [11:0] paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error
  output logic      [7:0]  prescaler_cfg, // prescaler config out
  output logic             sleep_mode,    // standby requested
  output logic             flush_pulse    // prefetch discarded
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  function automatic logic [15:0] sext6(input logic [5:0] k);
    return {{10{k[5]}}, k};
  endfunction : sext6

  cido_pkg::cido_state_type state_reg, state_next;
  logic [13:0]     ir_reg, pref_reg;
  logic            pref_valid_reg, pref_valid_next;
  logic [7:0]      acc_reg, acc_next;
  logic [15:0]     ptr_reg [2];
  logic [15:0]     ptr_next [2];
  logic [PC_W-1:0] pc_reg, pc_next;
  logic [PC_W-1:0] stack_reg [STACK_DEPTH];
  logic [SP_W-1:0] sp_reg, sp_next;
  logic [7:0]      dir_reg [8];
  logic [7:0]      file_reg [128];
  logic [7:0]      presc_next;
  logic            c_reg, dc_reg, z_reg, to_reg, pd_reg;
  logic            c_next, dc_next, z_next, to_next, pd_next;
  logic            sleep_next, disc_reg, disc_next;
  logic [15:0]     cycles_reg;
  logic [31:0]     rd_data;
  logic            flush_next;

  // instruction decode
  wire is_bra    = ir_reg[13:9] == `CIDO_OP_BRA;
  wire is_brw    = ir_reg == `CIDO_OP_BRW;
  wire is_call_by_acc  = ir_reg == `CIDO_OP_CALL_BY_ACC;
  wire is_return_literal  = ir_reg[13:8] == `CIDO_OP_RETURN_LITERAL;
  wire is_option = ir_reg == `CIDO_OP_OPTION;
  wire is_sleep  = ir_reg == `CIDO_OP_SLEEP;
  wire is_direction_load   = ir_reg[13:3] == `CIDO_OP_DIRECTION_LOAD && !is_option && !is_sleep && ir_reg != `CIDO_OP_CLRWDT;
  wire is_pointer_offset_add = ir_reg[13:7] == `CIDO_OP_POINTER_OFFSET_ADD;
  wire is_ldm    = ir_reg[13:3] == `CIDO_OP_LOAD_MOD;
  wire is_stm    = ir_reg[13:3] == `CIDO_OP_STORE_MOD;
  wire is_ldk    = ir_reg[13:7] == `CIDO_OP_LOAD_IDX;
  wire is_stk    = ir_reg[13:7] == `CIDO_OP_STORE_IDX;
  wire is_literal_add  = ir_reg[13:8] == `CIDO_OP_LITERAL_ADD;
  wire is_literal_and  = ir_reg[13:8] == `CIDO_OP_LITERAL_AND;
  wire is_file_and  = ir_reg[13:8] == `CIDO_OP_FILE_AND;
  wire is_xfer   = is_bra | is_brw | is_call_by_acc | is_return_literal;

  // indirect addressing; post modes use the old pointer
  wire        n_sel        = (is_ldm | is_stm) ? ir_reg[2] : ir_reg[6];
  wire [1:0]  ptr_upd_sel  = ir_reg[1:0];
  wire [15:0] ptr_cur      = ptr_reg[n_sel];
  wire [15:0] ptr_step     = ptr_upd_sel[0] ? ptr_cur - 16'h0001 : ptr_cur + 16'h0001;
  wire [15:0] ptr_off      = ptr_cur + sext6(ir_reg[5:0]);
  wire        is_idx       = is_ldk | is_stk;
  wire        is_mod       = is_ldm | is_stm;
  wire [15:0] ind_addr     = is_idx ? ptr_off : (ptr_upd_sel[1] ? ptr_cur : ptr_step);
  wire        need_extra   = (is_idx | is_mod) & ptr_cur[15];
  wire [7:0]  ind_val      = file_reg[ind_addr[6:0]];
  wire [7:0]  file_and_res    = acc_reg & file_reg[ir_reg[6:0]];
  wire [8:0]  add_sum      = {1'b0, acc_reg} + {1'b0, ir_reg[7:0]};
  wire [4:0]  add_nib      = {1'b0, acc_reg[3:0]} + {1'b0, ir_reg[3:0]};

  // sequencer strobes
  wire ex       = state_reg == cido_pkg::s_exec;
  wire idle     = state_reg == cido_pkg::s_idle;
  wire issue    = idle & pref_valid_reg & !sleep_mode;
  wire ex_load  = ex & (is_ldm | is_ldk);
  wire ex_store = ex & (is_stm | is_stk);
  wire ex_fand  = ex & is_file_and;
  wire ex_z     = ex_load | ex & (is_literal_add | is_literal_and | is_file_and);
  // the word taken while a transfer executes is the one that it skips
  wire drop     = ex & is_xfer & (pref_valid_reg | w_ins);
  wire [7:0] ex_res = ex_load  ? ind_val :
                      is_literal_add ? add_sum[7:0] :
                      is_literal_and ? acc_reg & ir_reg[7:0] : file_and_res;

  // apb decode; execution-owned registers refuse writes while busy
  wire acc_ph   = psel & penable;
  wire hit_ins  = paddr == `CIDO_OFF_INSTR;
  wire hit_st   = paddr == `CIDO_OFF_STATUS;
  wire hit_acc  = paddr == `CIDO_OFF_ACC;
  wire hit_p0   = paddr == `CIDO_OFF_PTR0;
  wire hit_p1   = paddr == `CIDO_OFF_PTR1;
  wire hit_pc   = paddr == `CIDO_OFF_PC;
  wire hit_ps   = paddr == `CIDO_OFF_PRESC;
  wire hit_cyc  = paddr == `CIDO_OFF_CYCLES;
  wire hit_dir  = (paddr & `CIDO_MASK_DIR) == `CIDO_OFF_DIR;
  wire hit_file = (paddr & `CIDO_MASK_FILE) == `CIDO_OFF_FILE;
  wire aligned  = paddr[1:0] == 2'b00;
  wire mapped   = aligned & (hit_ins | hit_st | hit_acc | hit_p0 | hit_p1 | hit_pc | hit_ps | hit_cyc
                             | hit_dir | hit_file);
  wire guarded  = hit_st | hit_acc | hit_p0 | hit_p1 | hit_pc | hit_file;
  wire ro_hit   = hit_ps | hit_cyc | hit_dir;
  wire bad      = !mapped | pwrite & (ro_hit | guarded & !idle | hit_ins & pref_valid_reg);
  wire w_ok     = acc_ph & pwrite & !bad;
  wire w_ins    = w_ok & hit_ins;
  wire w_st     = w_ok & hit_st;
  wire w_acc    = w_ok & hit_acc;
  wire w_pc     = w_ok & hit_pc;
  wire w_file   = w_ok & hit_file;

  // file write port shared by stores, file and with d=1, and the bus
  wire       mem_we = ex_store | ex_fand & ir_reg[7] | w_file;
  wire [6:0] mem_wa = ex_store ? ind_addr[6:0] : ex ? ir_reg[6:0] : paddr[8:2];
  wire [7:0] mem_wd = ex_store ? acc_reg : ex ? file_and_res : pwdata[7:0];

  // control transfer targets
  wire [PC_W-1:0] pc_inc   = pc_reg + PC_W'(1);
  wire [PC_W-1:0] bra_tgt  = pc_inc + {{(PC_W-9){ir_reg[8]}}, ir_reg[8:0]};
  wire [PC_W-1:0] brw_tgt  = pc_inc + {{(PC_W-8){1'b0}}, acc_reg};
  wire [PC_W-1:0] call_tgt = {pc_reg[PC_W-1:8], acc_reg};
  wire [SP_W-1:0] sp_dec   = sp_reg - SP_W'(1);
  wire [PC_W-1:0] ret_tgt  = stack_reg[sp_dec];
  wire            do_push  = ex & is_call_by_acc;
  wire            do_pop   = ex & is_return_literal;

  // next values of core state
  assign pc_next = !ex ? (w_pc ? pwdata[PC_W-1:0] : pc_reg) :
                   is_bra ? bra_tgt : is_brw ? brw_tgt : is_call_by_acc ? call_tgt :
                   is_return_literal ? ret_tgt : pc_inc;
  assign sp_next = do_push ? sp_reg + SP_W'(1) : do_pop ? sp_dec : sp_reg;
  assign acc_next = do_pop ? ir_reg[7:0] :
                    ex_z & !(is_file_and & ir_reg[7]) ? ex_res : w_acc ? pwdata[7:0] : acc_reg;
  assign z_next  = ex_z ? ex_res == 8'h00 : w_st ? pwdata[`CIDO_ST_Z] : z_reg;
  assign c_next  = ex & is_literal_add ? add_sum[8] : w_st ? pwdata[`CIDO_ST_C] : c_reg;
  assign dc_next = ex & is_literal_add ? add_nib[4] : w_st ? pwdata[`CIDO_ST_DC] : dc_reg;
  // standby raises the expiry bit and drops the powerdown bit
  assign to_next = ex & is_sleep ? 1'b1 : w_st ? pwdata[`CIDO_ST_TO] : to_reg;
  assign pd_next = ex & is_sleep ? 1'b0 : w_st ? pwdata[`CIDO_ST_PD] : pd_reg;
  assign sleep_next = ex & is_sleep | sleep_mode & !(w_st & !pwdata[`CIDO_ST_SLEEP]);
  assign presc_next = ex & is_option ? acc_reg : prescaler_cfg;
  // a discard in the same cycle as its clear is kept
  assign disc_next = drop | disc_reg & !(w_st & pwdata[`CIDO_ST_DISC]);
  assign flush_next = drop;
  // a word written in the dead cycle after a redirect is the new target and is kept
  assign pref_valid_next = (w_ins | pref_valid_reg & !issue) & !drop;

  // pointer pairs: add, pre/post modify, or bus write
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ptr_next[i] = ptr_reg[i];
      if (ex && n_sel == i[0] && is_pointer_offset_add) begin
        ptr_next[i] = ptr_off;
      end else if (ex && n_sel == i[0] && is_mod) begin
        ptr_next[i] = ptr_step;
      end else if (w_ok && (i == 0 ? hit_p0 : hit_p1)) begin
        ptr_next[i] = pwdata[15:0];
      end
    end
  end

  // sequencer: redirects get a dead second cycle, msb-set pointers an extra one
  always_comb begin
    case (state_reg)
      cido_pkg::s_idle:  state_next = issue ? cido_pkg::s_exec : cido_pkg::s_idle;
      cido_pkg::s_exec:  state_next = is_xfer ? cido_pkg::s_flush :
                                      need_extra ? cido_pkg::s_extra : cido_pkg::s_idle;
      default:           state_next = cido_pkg::s_idle;
    endcase
  end

  // read mux
  wire [31:0] status_word = {19'h00000, pd_reg, to_reg, z_reg, dc_reg, c_reg, 4'h0,
                             sleep_mode, disc_reg, pref_valid_reg, !idle};
  assign rd_data = hit_st  ? status_word :
                   hit_acc ? {24'h000000, acc_reg} :
                   hit_p0  ? {16'h0000, ptr_reg[0]} :
                   hit_p1  ? {16'h0000, ptr_reg[1]} :
                   hit_pc  ? 32'(pc_reg) :
                   hit_ps  ? {24'h000000, prescaler_cfg} :
                   hit_cyc ? {16'h0000, cycles_reg} :
                   hit_dir ? {24'h000000, dir_reg[paddr[4:2]]} :
                   hit_file ? {24'h000000, file_reg[paddr[8:2]]} : 32'h00000000;
  // zero wait: data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = acc_ph & bad;

  // bus and sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= cido_pkg::s_idle;
      ir_reg         <= 14'h0000;
      pref_reg       <= 14'h0000;
      pref_valid_reg <= 1'b0;
      prdata         <= 32'h00000000;
      cycles_reg     <= 16'h0000;
      disc_reg       <= 1'b0;
      flush_pulse    <= 1'b0;
    end else begin
      state_reg      <= state_next;
      ir_reg         <= issue ? pref_reg : ir_reg;
      pref_reg       <= w_ins ? pwdata[13:0] : pref_reg;
      pref_valid_reg <= pref_valid_next;
      prdata         <= (psel & !penable & !pwrite) ? rd_data : prdata;
      cycles_reg     <= idle ? cycles_reg : cycles_reg + 16'h0001;
      disc_reg       <= disc_next;
      flush_pulse    <= flush_next;
    end
  end

  // accumulator, flags, pointers, program counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg       <= `CIDO_RST_BYTE;
      prescaler_cfg <= `CIDO_RST_BYTE;
      {c_reg, dc_reg, z_reg} <= 3'h0;
      to_reg        <= `CIDO_RST_NFLAG;
      pd_reg        <= `CIDO_RST_NFLAG;
      sleep_mode    <= 1'b0;
      ptr_reg[0]    <= `CIDO_RST_PTR;
      ptr_reg[1]    <= `CIDO_RST_PTR;
      pc_reg        <= '0;
      sp_reg        <= '0;
    end else begin
      acc_reg       <= acc_next;
      prescaler_cfg <= presc_next;
      {c_reg, dc_reg, z_reg} <= {c_next, dc_next, z_next};
      to_reg        <= to_next;
      pd_reg        <= pd_next;
      sleep_mode    <= sleep_next;
      ptr_reg[0]    <= ptr_next[0];
      ptr_reg[1]    <= ptr_next[1];
      pc_reg        <= pc_next;
      sp_reg        <= sp_next;
    end
  end

  // storage arrays; the return stack wraps silently when overfilled
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      file_reg[mem_wa] <= mem_wd;
    end
    if (ex & is_direction_load) begin
      dir_reg[ir_reg[2:0]] <= acc_reg;
    end
    if (do_push) begin
      stack_reg[sp_reg] <= pc_inc;
    end
  end

  a_xfer_dead_cycle:
    assert property (@(posedge pclk) disable iff (!presetn)
      ex && is_xfer |=> state_reg == cido_pkg::s_flush ##1 state_reg == cido_pkg::s_idle)
    else $error("redirect did not take exactly two cycles");
  a_brw_target:
    assert property (@(posedge pclk) disable iff (!presetn)
      ex && is_brw |=> pc_reg == $past(pc_reg) + PC_W'(1) + PC_W'($past(acc_reg)))
    else $error("accumulator branch target wrong");
  a_call_by_acc_push:
    assert property (@(posedge pclk) disable iff (!presetn)
      ex && is_call_by_acc |=> sp_reg == $past(sp_reg) + SP_W'(1) && pc_reg[7:0] == $past(acc_reg))
    else $error("accumulator call did not push or jump");
  a_return_literal_value:
    assert property (@(posedge pclk) disable iff (!presetn)
      ex && is_return_literal |=> acc_reg == $past(ir_reg[7:0]) && sp_reg == $past(sp_reg) - SP_W'(1))
    else $error("literal return wrong");
  a_option_copy:
    assert property (@(posedge pclk) disable iff (!presetn)
      ex && is_option |=> prescaler_cfg == $past(acc_reg) && $stable({c_reg, dc_reg, z_reg}))
    else $error("prescaler load wrong");
  a_sleep_flags:
    assert property (@(posedge pclk) disable iff (!presetn)
      ex && is_sleep |=> to_reg && !pd_reg && sleep_mode)
    else $error("standby flags wrong");
  a_pointer_offset_add_wrap:
    assert property (@(posedge pclk) disable iff (!presetn)
      ex && is_pointer_offset_add && !ir_reg[6] |=> ptr_reg[0] == $past(ptr_reg[0]) + sext6($past(ir_reg[5:0])))
    else $error("pointer add wrong");
  a_extra_cycle:
    assert property (@(posedge pclk) disable iff (!presetn)
      ex && need_extra |=> state_reg == cido_pkg::s_extra ##1 idle)
    else $error("missing extra indirect cycle");
  a_prefetch_drop:
    assert property (@(posedge pclk) disable iff (!presetn)
      ex && is_xfer && (pref_valid_reg || w_ins) |=> disc_reg && flush_pulse && !pref_valid_reg)
    else $error("prefetched word not discarded");
  a_literal_add_flags:
    assert property (@(posedge pclk) disable iff (!presetn)
      ex && is_literal_add |=> c_reg == $past(add_sum[8]) && z_reg == (acc_reg == 8'h00))
    else $error("literal add flags wrong");
  a_dir_load:
    assert property (@(posedge pclk) disable iff (!presetn)
      ex && is_direction_load |=> dir_reg[$past(ir_reg[2:0])] == $past(acc_reg))
    else $error("direction load wrong");
  a_mod_step:
    assert property (@(posedge pclk) disable iff (!presetn)
      ex && is_mod && !ir_reg[2] |=> ptr_reg[0] == $past(ptr_reg[0]) + ($past(ir_reg[0]) ? 16'hffff : 16'h0001))
    else $error("pointer modify step wrong");
  a_idx_zero:
    assert property (@(posedge pclk) disable iff (!presetn)
      ex && is_ldk |=> z_reg == (acc_reg == 8'h00))
    else $error("indexed load zero flag wrong");
  a_store_flags:
    assert property (@(posedge pclk) disable iff (!presetn)
      ex && (is_stm || is_stk) |=> $stable({c_reg, dc_reg, z_reg, to_reg, pd_reg}))
    else $error("indirect store touched a flag");
  a_bra_target:
    assert property (@(posedge pclk) disable iff (!presetn)
      ex && is_bra |=> pc_reg == $past(pc_reg) + PC_W'(1) + PC_W'($signed($past(ir_reg[8:0]))))
    else $error("relative jump target wrong");
  a_literal_and_value:
    assert property (@(posedge pclk) disable iff (!presetn)
      ex && is_literal_and |=> acc_reg == ($past(acc_reg) & $past(ir_reg[7:0])) && $stable({c_reg, dc_reg}))
    else $error("literal and wrong");
  a_fand_dest:
    assert property (@(posedge pclk) disable iff (!presetn)
      ex && is_file_and && ir_reg[7] |=> $stable(acc_reg)
        && file_reg[$past(ir_reg[6:0])] == ($past(acc_reg) & $past(file_reg[ir_reg[6:0]])))
    else $error("file and destination wrong");
endmodule : cido_core

// ---- test/cido_apb_master.sv ----
`timescale 1ns/1ps
// apb requester standing in for the fetch side; idle cycle between transfers unless held
module cido_apb_master (
  input  wire logic        pclk,    // bus clock
  output logic             psel,    // select
  output logic             penable, // access phase
  output logic             pwrite,  // direction
  output logic      [11:0] paddr,   // byte address
  output logic      [31:0] pwdata,  // write data
  input  wire logic [31:0] prdata,  // read data
  input  wire logic        pready,  // ready
  input  wire logic        pslverr  // error
);
  logic chain_q; // previous transfer left the bus held for a back-to-back setup

  initial begin
    chain_q = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h00000000;
  end

  // request held until pready is seen high; data inverted after release so stale values never match
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic hold,
                      output logic [31:0] q, output logic err);
    if (!chain_q) begin
      @(posedge pclk);
    end
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q       = prdata;
    err     = pslverr;
    chain_q = hold;
    if (!hold) begin
      psel    <= 1'b0;
      penable <= 1'b0;
      pwdata  <= ~d;
    end
  endtask : xfer
endmodule : cido_apb_master

// ---- test/cido_core_tb.sv ----
`timescale 1ns/1ps
`include "cido_params.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module cido_core_tb;
  logic        pclk;
  logic        presetn;
  logic        psel, penable, pwrite, pready, pslverr, sleep_mode, flush_pulse;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, c0;
  logic [7:0]  prescaler_cfg;
  logic        e;
  int          error_cnt, n_checks, cyc;

  cido_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prescaler_cfg(prescaler_cfg), .sleep_mode(sleep_mode), .flush_pulse(flush_pulse));
  cido_apb_master m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // a hang would otherwise stall the run forever
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    m.xfer(1'b1, a, d, 1'b0, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    m.xfer(1'b0, a, 32'h00000000, 1'b0, q, e);
  endtask : rd
  // issue one opcode, wait for idle, compare the cycle count spent
  task automatic ex(input logic [13:0] op, input logic [31:0] n);
    rd(`CIDO_OFF_CYCLES);
    c0 = q;
    wr(`CIDO_OFF_INSTR, {18'h00000, op});
    for (int i = 0; i < 20; i++) begin
      rd(`CIDO_OFF_STATUS);
      if (q[1:0] === 2'b00) break;
    end
    rd(`CIDO_OFF_CYCLES);
    `CHK(q - c0, n)
  endtask : ex

  task automatic t_alu();
    rd(`CIDO_OFF_STATUS); `CHK(q, 32'h00001800)
    wr(`CIDO_OFF_ACC, 32'h8f); ex(14'h3e71, 1);
    rd(`CIDO_OFF_ACC); `CHK(q, 32'h0)
    rd(`CIDO_OFF_STATUS); `CHK(q[10:8], 3'b111)
    wr(`CIDO_OFF_ACC, 32'hf0); ex(14'h393c, 1);
    rd(`CIDO_OFF_ACC); `CHK(q, 32'h30)
    rd(`CIDO_OFF_STATUS); `CHK(q[10:8], 3'b011)
    wr(12'h214, 32'h3c); wr(`CIDO_OFF_ACC, 32'h0c); ex(14'h0585, 1);
    rd(12'h214); `CHK(q, 32'h0c)
    wr(`CIDO_OFF_ACC, 32'h03); ex(14'h0505, 1);
    rd(`CIDO_OFF_ACC); `CHK(q, 32'h0)
    rd(`CIDO_OFF_STATUS); `CHK(q[10], 1'b1)
    $display("alu test done");
  endtask : t_alu

  // wrap at both ends of the pointer pair
  task automatic t_ptr();
    wr(`CIDO_OFF_PTR0, 32'hffff); wr(`CIDO_OFF_PTR1, 32'h0); wr(`CIDO_OFF_STATUS, 32'h0);
    ex(14'h3101, 1);
    ex(14'h3160, 1);
    rd(`CIDO_OFF_PTR0); `CHK(q, 32'h0)
    rd(`CIDO_OFF_PTR1); `CHK(q, 32'hffe0)
    rd(`CIDO_OFF_STATUS); `CHK(q[12:8], 5'h00)
    $display("pointer test done");
  endtask : t_ptr

  task automatic t_ind();
    wr(`CIDO_OFF_ACC, 32'ha5); wr(`CIDO_OFF_PTR0, 32'h5); ex(14'h001a, 1);
    rd(`CIDO_OFF_PTR0); `CHK(q, 32'h6)
    wr(`CIDO_OFF_ACC, 32'h0); ex(14'h0011, 1);
    rd(`CIDO_OFF_ACC); `CHK(q, 32'ha5)
    rd(`CIDO_OFF_PTR0); `CHK(q, 32'h5)
    rd(`CIDO_OFF_STATUS); `CHK(q[12:8], 5'h00)
    wr(`CIDO_OFF_PTR1, 32'h3); ex(14'h3f42, 1);
    rd(`CIDO_OFF_ACC); `CHK(q, 32'ha5)
    wr(`CIDO_OFF_ACC, 32'h0); ex(14'h3fc3, 1);
    wr(`CIDO_OFF_ACC, 32'h11); ex(14'h3f43, 1);
    rd(`CIDO_OFF_ACC); `CHK(q, 32'h0)
    rd(`CIDO_OFF_STATUS); `CHK(q[10], 1'b1)
    wr(`CIDO_OFF_PTR0, 32'h8007); ex(14'h001a, 2);
    $display("indirect test done");
  endtask : t_ind

  task automatic t_flow();
    wr(`CIDO_OFF_PC, 32'h10); wr(`CIDO_OFF_ACC, 32'h3); ex(14'h000b, 2);
    rd(`CIDO_OFF_PC); `CHK(q, 32'h14)
    wr(`CIDO_OFF_PC, 32'h200); ex(14'h3300, 2);
    rd(`CIDO_OFF_PC); `CHK(q, 32'h101)
    wr(`CIDO_OFF_PC, 32'h123); wr(`CIDO_OFF_ACC, 32'h45); ex(14'h000a, 2);
    rd(`CIDO_OFF_PC); `CHK(q, 32'h145)
    ex(14'h3499, 2);
    rd(`CIDO_OFF_PC); `CHK(q, 32'h124)
    rd(`CIDO_OFF_ACC); `CHK(q, 32'h99)
    $display("flow test done");
  endtask : t_flow

  task automatic t_inh();
    wr(`CIDO_OFF_ACC, 32'h5a); wr(`CIDO_OFF_STATUS, 32'h0); ex(14'h0062, 1);
    `CHK(prescaler_cfg, 8'h5a)
    rd(`CIDO_OFF_STATUS); `CHK(q[12:8], 5'h00)
    ex(14'h0065, 1);
    rd(12'h054); `CHK(q, 32'h5a)
    ex(14'h0063, 1);
    `CHK(sleep_mode, 1'b1)
    rd(`CIDO_OFF_STATUS); `CHK(q[12:11], 2'b01)
    wr(`CIDO_OFF_STATUS, 32'h1800);
    @(posedge pclk);
    `CHK(sleep_mode, 1'b0)
    $display("inherent test done");
  endtask : t_inh

  // refused accesses must leave state alone
  task automatic t_err();
    wr(12'h020, 32'h1); `CHK(e, 1'b1)
    wr(12'h006, 32'h1); `CHK(e, 1'b1)
    wr(`CIDO_OFF_PRESC, 32'h0); `CHK(e, 1'b1)
    rd(`CIDO_OFF_PRESC); `CHK(q, 32'h5a)
    $display("refusal test done");
  endtask : t_err

  // a word written back to back behind a redirect lands in its execute cycle and must be skipped
  task automatic t_drop();
    wr(`CIDO_OFF_PC, 32'h30); wr(`CIDO_OFF_ACC, 32'h02);
    m.xfer(1'b1, `CIDO_OFF_INSTR, 32'h000b, 1'b1, q, e);
    m.xfer(1'b1, `CIDO_OFF_INSTR, 32'h3e01, 1'b0, q, e); `CHK(e, 1'b0)
    @(posedge pclk); `CHK(flush_pulse, 1'b1)
    @(posedge pclk); `CHK(flush_pulse, 1'b0)
    rd(`CIDO_OFF_STATUS); `CHK(q[2:0], 3'b100)
    rd(`CIDO_OFF_PC); `CHK(q, 32'h33)
    rd(`CIDO_OFF_ACC); `CHK(q, 32'h02)
    wr(`CIDO_OFF_STATUS, 32'h1804); rd(`CIDO_OFF_STATUS); `CHK(q, 32'h00001800)
    $display("discard test done");
  endtask : t_drop

  initial begin
    error_cnt = 0;
    n_checks  = 0;
    cyc       = 0;
    presetn   = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_alu();
    t_ptr();
    t_ind();
    t_flow();
    t_inh();
    t_err();
    t_drop();
    summarize();
  end
endmodule : cido_core_tb
